// *** hdl/ref_sel_pkg.sv ***
// Constants, register map and types for the reference select and mode control block
package ref_sel_pkg;

  // Clock and timing
  localparam int CLK_MHZ           = 100;
  localparam int LOCK_TIME_US      = 100;
  localparam int LOCK_CYCLES       = LOCK_TIME_US * CLK_MHZ;
  localparam int ACT_WINDOW_US     = 10;
  localparam int ACT_WINDOW_CYCLES = ACT_WINDOW_US * CLK_MHZ;
  localparam int FRAME_PERIOD_NS   = 125000;
  localparam int FRAME_CYCLES      = FRAME_PERIOD_NS * CLK_MHZ / 1000;
  localparam int MF_FRAMES         = 4;
  // Sync rate classification bounds (midpoints between 8, 4, 2 and 1 kHz periods)
  localparam int SYNC_8K_MAX_NS    = 187500;
  localparam int SYNC_4K_MAX_NS    = 375000;
  localparam int SYNC_2K_MAX_NS    = 750000;
  localparam int SYNC_8K_MAX       = SYNC_8K_MAX_NS * CLK_MHZ / 1000;
  localparam int SYNC_4K_MAX       = SYNC_4K_MAX_NS * CLK_MHZ / 1000;
  localparam int SYNC_2K_MAX       = SYNC_2K_MAX_NS * CLK_MHZ / 1000;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_PRIORITY  = 8'h04;
  localparam logic [7:0] OFS_BUCKET_ID = 8'h08;
  localparam logic [7:0] OFS_FAST_LOSS = 8'h0c;
  localparam logic [7:0] OFS_BKT_CFG0  = 8'h10;
  localparam logic [7:0] OFS_CAL_WORD  = 8'h20;
  localparam logic [7:0] OFS_SYNC_CFG  = 8'h24;
  localparam logic [7:0] OFS_OUT_DIV0  = 8'h30;
  localparam logic [7:0] OFS_STATUS    = 8'h48;
  localparam logic [7:0] OFS_FREQ      = 8'h4c;
  localparam logic [7:0] OFS_CHANGE    = 8'h50;

  // Control register fields
  localparam int CTRL_REVERTIVE = 0;
  localparam int CTRL_FORCE_EN  = 1;
  localparam int CTRL_FORCE_LSB = 2;
  localparam int CTRL_FAST_EN   = 4;

  // Reset values
  localparam logic [4:0]  CTRL_RST      = 5'h01;
  localparam logic [11:0] PRIORITY_RST  = 12'h432;
  localparam logic [5:0]  BUCKET_ID_RST = 6'h00;
  localparam logic [15:0] FAST_LOSS_RST = 16'h0010;
  localparam logic [31:0] BKT_CFG_RST   = 32'h04020608;
  localparam logic [18:0] CAL_WORD_RST  = 19'h00000;
  localparam logic [17:0] SYNC_CFG_RST  = 18'h00101;
  localparam logic [15:0] OUT_DIV_RST   = 16'h0004;

  // Reference indices
  localparam logic [1:0] REF_MASTER  = 2'h0;
  localparam logic [1:0] REF_SLAVE   = 2'h1;
  localparam logic [1:0] REF_STANDBY = 2'h2;
  localparam logic [1:0] REF_NONE    = 2'h3;

  // Detected sync rate codes
  localparam logic [1:0] RATE_NONE = 2'h0;
  localparam logic [1:0] RATE_2K   = 2'h1;
  localparam logic [1:0] RATE_4K   = 2'h2;
  localparam logic [1:0] RATE_8K   = 2'h3;

  typedef enum logic [1:0] {FREE_RUN, LOCKED, HOLDOVER} op_mode_t;

endpackage : ref_sel_pkg

// *** hdl/reference_select_mode_control.sv ***
// Reference selection, qualification, operating mode and sync generation with Avalon-MM registers
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module reference_select_mode_control #(
  parameter int LOCK_CYCLES_P  = ref_sel_pkg::LOCK_CYCLES,
  parameter int FRAME_CYCLES_P = ref_sel_pkg::FRAME_CYCLES,
  parameter int SYNC_8K_MAX_P  = ref_sel_pkg::SYNC_8K_MAX,
  parameter int SYNC_4K_MAX_P  = ref_sel_pkg::SYNC_4K_MAX,
  parameter int SYNC_2K_MAX_P  = ref_sel_pkg::SYNC_2K_MAX
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Reference clock and sync pins
  input  wire logic        masterRefClock,
  input  wire logic        slaveRefClock,
  input  wire logic        standbyRefClock,
  input  wire logic        masterSyncRef,
  input  wire logic        slaveSyncRef,
  input  wire logic        standbySyncRef,
  input  wire logic        forcedSwitchPin,
  // Loop frequency word from the loop filter
  input  wire logic [18:0] loopFreqWord,
  // Outputs
  output logic      [18:0] freqWord,
  output logic      [1:0]  operatingMode,
  output logic      [1:0]  selectedRef,
  output logic             frameSyncOut,
  output logic             multiframeSyncOut,
  output logic             diffClockOut,
  output logic      [4:0]  singleEndedClockOut
);

  localparam int NREF = 3;
  localparam int NOUT = 6;

  // Pin synchronisers: first stage feeds only the second
  logic [2:0] clkMeta_reg, clkSync_reg, clkPrev_reg;
  logic [2:0] synMeta_reg, synSync_reg, synPrev_reg;
  logic       pinMeta_reg, pinSync_reg;
  logic [2:0] clkEdge, synEdge;

  always_ff @(posedge clk) begin
    clkMeta_reg <= {standbyRefClock, slaveRefClock, masterRefClock};
    clkSync_reg <= clkMeta_reg;
    clkPrev_reg <= clkSync_reg;
    synMeta_reg <= {standbySyncRef, slaveSyncRef, masterSyncRef};
    synSync_reg <= synMeta_reg;
    synPrev_reg <= synSync_reg;
    pinMeta_reg <= forcedSwitchPin;
    pinSync_reg <= pinMeta_reg;
  end

  assign clkEdge = clkSync_reg & ~clkPrev_reg;
  assign synEdge = synSync_reg & ~synPrev_reg;

  // Configuration registers
  logic [4:0]  ctrl_reg, ctrl_next;
  logic [11:0] prio_reg, prio_next;
  logic [5:0]  bktId_reg, bktId_next;
  logic [15:0] fastLoss_reg, fastLoss_next;
  logic [31:0] bktCfg_reg [4], bktCfg_next [4];
  logic [18:0] calWord_reg, calWord_next;
  logic [17:0] syncCfg_reg, syncCfg_next;
  logic [15:0] outDiv_reg [NOUT], outDiv_next [NOUT];
  logic        change_reg, change_next;
  logic [31:0] readdata_reg, readdata_next;
  logic        waitreq_reg, waitreq_next;

  // Block state visible to the bus, and the previous validity kept for change detection
  logic [2:0]  refValid;
  logic [1:0]  syncRate [NREF];
  ref_sel_pkg::op_mode_t mode_reg, mode_next;
  logic [1:0]  sel_reg, sel_next;
  logic [18:0] freq_reg, freq_next;
  logic [2:0]  validPrev_reg;

  // Window tick shared by the activity monitors
  logic [15:0] winCnt_reg, winCnt_next;
  logic        winTick;

  always_comb begin
    winTick     = (winCnt_reg == 16'(ref_sel_pkg::ACT_WINDOW_CYCLES - 1));
    winCnt_next = winTick ? 16'h0000 : winCnt_reg + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) winCnt_reg <= 16'h0000;
    else        winCnt_reg <= winCnt_next;
  end

  // Per-reference activity monitor, leaky bucket and sync rate detector
  for (genvar i = 0; i < NREF; i++) begin : g_ref
    logic [15:0] idle_reg, idle_next;
    logic        saw_reg, saw_next;
    logic [7:0]  bucket_reg, bucket_next;
    logic [7:0]  leak_reg, leak_next;
    logic        alarm_reg, alarm_next;
    logic [16:0] sPer_reg, sPer_next;
    logic [1:0]  rate_reg, rate_next;
    logic [31:0] cfg;
    logic        fastLoss;

    always_comb begin
      cfg         = bktCfg_reg[bktId_reg[2*i +: 2]];
      idle_next   = clkEdge[i] ? 16'h0000 : (&idle_reg ? idle_reg : idle_reg + 16'h0001);
      fastLoss    = ctrl_reg[ref_sel_pkg::CTRL_FAST_EN] && (idle_reg >= fastLoss_reg);
      saw_next    = winTick ? 1'b0 : (saw_reg | clkEdge[i]);
      bucket_next = bucket_reg;
      leak_next   = leak_reg;
      if (winTick) begin
        if (!(saw_reg | clkEdge[i])) begin
          bucket_next = (bucket_reg >= cfg[7:0]) ? cfg[7:0] : bucket_reg + 8'h01;
        end else if (leak_reg >= cfg[31:24]) begin
          leak_next   = 8'h00;
          bucket_next = (bucket_reg != 8'h00) ? bucket_reg - 8'h01 : 8'h00;
        end else begin
          leak_next = leak_reg + 8'h01;
        end
      end
      // Hysteresis between set and clear thresholds avoids chatter
      alarm_next = alarm_reg;
      if (fastLoss || bucket_reg >= cfg[15:8]) alarm_next = 1'b1;
      else if (bucket_reg <= cfg[23:16] && saw_reg) alarm_next = 1'b0;
      // Sync rate from the period between rising edges
      sPer_next = synEdge[i] ? 17'h00000 : (sPer_reg >= 17'(SYNC_2K_MAX_P) ? sPer_reg : sPer_reg + 17'h00001);
      rate_next = rate_reg;
      if (sPer_reg >= 17'(SYNC_2K_MAX_P))      rate_next = ref_sel_pkg::RATE_NONE;
      else if (synEdge[i]) begin
        if (sPer_reg < 17'(SYNC_8K_MAX_P))      rate_next = ref_sel_pkg::RATE_8K;
        else if (sPer_reg < 17'(SYNC_4K_MAX_P)) rate_next = ref_sel_pkg::RATE_4K;
        else                                    rate_next = ref_sel_pkg::RATE_2K;
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        idle_reg   <= 16'h0000;
        saw_reg    <= 1'b0;
        bucket_reg <= 8'h00;
        leak_reg   <= 8'h00;
        alarm_reg  <= 1'b1;
        sPer_reg   <= 17'h00000;
        rate_reg   <= ref_sel_pkg::RATE_NONE;
      end else begin
        idle_reg   <= idle_next;
        saw_reg    <= saw_next;
        bucket_reg <= bucket_next;
        leak_reg   <= leak_next;
        alarm_reg  <= alarm_next;
        sPer_reg   <= sPer_next;
        rate_reg   <= rate_next;
      end
    end

    // Validity comes from the clock alone; the sync has no say
    assign refValid[i] = !alarm_reg;
    assign syncRate[i] = rate_reg;
  end

  // Priority search: lowest non-zero number wins, zero disables the input
  function automatic logic [1:0] pickBest(input logic [2:0] v, input logic [11:0] p);
    logic [1:0] best;
    logic [3:0] bestP;
    best  = ref_sel_pkg::REF_NONE;
    bestP = 4'hf;
    for (int k = 0; k < NREF; k++) begin
      if (v[k] && p[4*k +: 4] != 4'h0 && (best == ref_sel_pkg::REF_NONE || p[4*k +: 4] < bestP)) begin
        best  = 2'(k);
        bestP = p[4*k +: 4];
      end
    end
    return best;
  endfunction : pickBest

  function automatic logic isValid(input logic [2:0] v, input logic [1:0] r);
    return (r != ref_sel_pkg::REF_NONE) && v[r];
  endfunction : isValid

  // Selection and operating mode
  logic [1:0]  best, cand;
  logic [19:0] acq_reg, acq_next;

  always_comb begin
    best = pickBest(refValid, prio_reg);
    if (pinSync_reg)                                      cand = ref_sel_pkg::REF_SLAVE;
    else if (ctrl_reg[ref_sel_pkg::CTRL_FORCE_EN])        cand = ctrl_reg[ref_sel_pkg::CTRL_FORCE_LSB +: 2];
    else if (ctrl_reg[ref_sel_pkg::CTRL_REVERTIVE])       cand = best;
    else if (isValid(refValid, sel_reg))                  cand = sel_reg;
    else                                                  cand = best;
    sel_next  = isValid(refValid, cand) ? cand : ref_sel_pkg::REF_NONE;
    mode_next = mode_reg;
    acq_next  = acq_reg;
    freq_next = freq_reg;
    case (mode_reg)
      ref_sel_pkg::FREE_RUN, ref_sel_pkg::HOLDOVER: begin
        if (mode_reg == ref_sel_pkg::FREE_RUN) freq_next = calWord_reg;
        if (sel_next == ref_sel_pkg::REF_NONE) acq_next = 20'h00000;
        else if (acq_reg >= 20'(LOCK_CYCLES_P - 1)) begin
          acq_next  = 20'h00000;
          mode_next = ref_sel_pkg::LOCKED;
        end else acq_next = acq_reg + 20'h00001;
      end
      ref_sel_pkg::LOCKED: begin
        // A switch between valid references keeps lock; phase is rebuilt by the loop
        if (sel_next == ref_sel_pkg::REF_NONE) mode_next = ref_sel_pkg::HOLDOVER;
        else freq_next = loopFreqWord;
      end
      default: mode_next = ref_sel_pkg::FREE_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_reg      <= ref_sel_pkg::FREE_RUN;
      sel_reg       <= ref_sel_pkg::REF_NONE;
      acq_reg       <= 20'h00000;
      freq_reg      <= ref_sel_pkg::CAL_WORD_RST;
      validPrev_reg <= 3'h0;
    end else begin
      mode_reg      <= mode_next;
      sel_reg       <= sel_next;
      acq_reg       <= acq_next;
      freq_reg      <= freq_next;
      validPrev_reg <= refValid;
    end
  end

  // Frame and multiframe sync generation, aligned to the selected group's sync
  logic [16:0] frm_reg, frm_next;
  logic [1:0]  mf_reg, mf_next;
  logic        fSync_reg, fSync_next, mfSync_reg, mfSync_next;
  logic        alignEdge;
  logic [1:0]  selRate;

  always_comb begin
    selRate   = (sel_reg == ref_sel_pkg::REF_NONE) ? ref_sel_pkg::RATE_NONE : syncRate[sel_reg];
    alignEdge = (sel_reg != ref_sel_pkg::REF_NONE) && synEdge[sel_reg] && (selRate != ref_sel_pkg::RATE_NONE);
    frm_next  = (frm_reg >= 17'(FRAME_CYCLES_P - 1)) ? 17'h00000 : frm_reg + 17'h00001;
    mf_next   = (frm_reg >= 17'(FRAME_CYCLES_P - 1)) ? 2'(mf_reg + 2'h1) : mf_reg;
    if (alignEdge) begin
      frm_next = 17'h00000;
      if (selRate == ref_sel_pkg::RATE_2K) mf_next = 2'h0;
    end
    fSync_next  = (frm_next < 17'(syncCfg_reg[7:0])) ^ syncCfg_reg[16];
    mfSync_next = (mf_next == 2'h0 && frm_next < 17'(syncCfg_reg[15:8])) ^ syncCfg_reg[17];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frm_reg    <= 17'h00000;
      mf_reg     <= 2'h0;
      fSync_reg  <= 1'b0;
      mfSync_reg <= 1'b0;
    end else begin
      frm_reg    <= frm_next;
      mf_reg     <= mf_next;
      fSync_reg  <= fSync_next;
      mfSync_reg <= mfSync_next;
    end
  end

  // Output clock dividers, one per port; a divider of zero squelches the port
  // Each divider owns its flop; the vector below only gathers them
  logic [NOUT-1:0] oClk;
  for (genvar o = 0; o < NOUT; o++) begin : g_out
    logic [15:0] cnt_reg, cnt_next;
    logic        oClk_reg, oClk_next;
    always_comb begin
      cnt_next  = cnt_reg + 16'h0001;
      oClk_next = oClk_reg;
      if (outDiv_reg[o] == 16'h0000) begin
        cnt_next  = 16'h0000;
        oClk_next = 1'b0;
      end else if (cnt_reg >= outDiv_reg[o] - 16'h0001) begin
        cnt_next  = 16'h0000;
        oClk_next = ~oClk_reg;
      end
    end
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cnt_reg  <= 16'h0000;
        oClk_reg <= 1'b0;
      end else begin
        cnt_reg  <= cnt_next;
        oClk_reg <= oClk_next;
      end
    end
    assign oClk[o] = oClk_reg;
  end

  // Avalon-MM register file: one wait cycle, access completes when waitrequest is low
  logic accept, doWrite, statusChange;

  always_comb begin
    accept        = (read || write) && waitreq_reg;
    doWrite       = write && !waitreq_reg;
    waitreq_next  = !accept;
    ctrl_next     = ctrl_reg;
    prio_next     = prio_reg;
    bktId_next    = bktId_reg;
    fastLoss_next = fastLoss_reg;
    calWord_next  = calWord_reg;
    syncCfg_next  = syncCfg_reg;
    bktCfg_next   = bktCfg_reg;
    outDiv_next   = outDiv_reg;
    change_next   = change_reg;
    if (doWrite) begin
      case (address)
        ref_sel_pkg::OFS_CTRL:      ctrl_next     = writedata[4:0];
        ref_sel_pkg::OFS_PRIORITY:  prio_next     = writedata[11:0];
        ref_sel_pkg::OFS_BUCKET_ID: bktId_next    = writedata[5:0];
        ref_sel_pkg::OFS_FAST_LOSS: fastLoss_next = writedata[15:0];
        ref_sel_pkg::OFS_CAL_WORD:  calWord_next  = writedata[18:0];
        ref_sel_pkg::OFS_SYNC_CFG:  syncCfg_next  = writedata[17:0];
        ref_sel_pkg::OFS_CHANGE:    if (writedata[0]) change_next = 1'b0;
        default: begin
          for (int k = 0; k < 4; k++)
            if (address == ref_sel_pkg::OFS_BKT_CFG0 + 8'(4*k)) bktCfg_next[k] = writedata;
          for (int k = 0; k < NOUT; k++)
            if (address == ref_sel_pkg::OFS_OUT_DIV0 + 8'(4*k)) outDiv_next[k] = writedata[15:0];
        end
      endcase
    end
    // A change in the same cycle as the clear keeps the flag set
    statusChange = (mode_next != mode_reg) || (sel_next != sel_reg) || (refValid != validPrev_reg);
    if (statusChange) change_next = 1'b1;
    readdata_next = readdata_reg;
    if (accept) begin
      readdata_next = 32'h00000000;
      case (address)
        ref_sel_pkg::OFS_CTRL:      readdata_next[4:0]   = ctrl_reg;
        ref_sel_pkg::OFS_PRIORITY:  readdata_next[11:0]  = prio_reg;
        ref_sel_pkg::OFS_BUCKET_ID: readdata_next[5:0]   = bktId_reg;
        ref_sel_pkg::OFS_FAST_LOSS: readdata_next[15:0]  = fastLoss_reg;
        ref_sel_pkg::OFS_CAL_WORD:  readdata_next[18:0]  = calWord_reg;
        ref_sel_pkg::OFS_SYNC_CFG:  readdata_next[17:0]  = syncCfg_reg;
        ref_sel_pkg::OFS_FREQ:      readdata_next[18:0]  = freq_reg;
        ref_sel_pkg::OFS_CHANGE:    readdata_next[0]     = change_reg;
        ref_sel_pkg::OFS_STATUS:    readdata_next[12:0]  = {syncRate[2], syncRate[1], syncRate[0],
                                                            refValid, sel_reg, mode_reg};
        default: begin
          for (int k = 0; k < 4; k++)
            if (address == ref_sel_pkg::OFS_BKT_CFG0 + 8'(4*k)) readdata_next = bktCfg_reg[k];
          for (int k = 0; k < NOUT; k++)
            if (address == ref_sel_pkg::OFS_OUT_DIV0 + 8'(4*k)) readdata_next[15:0] = outDiv_reg[k];
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg     <= ref_sel_pkg::CTRL_RST;
      prio_reg     <= ref_sel_pkg::PRIORITY_RST;
      bktId_reg    <= ref_sel_pkg::BUCKET_ID_RST;
      fastLoss_reg <= ref_sel_pkg::FAST_LOSS_RST;
      calWord_reg  <= ref_sel_pkg::CAL_WORD_RST;
      syncCfg_reg  <= ref_sel_pkg::SYNC_CFG_RST;
      for (int k = 0; k < 4; k++) bktCfg_reg[k] <= ref_sel_pkg::BKT_CFG_RST;
      for (int k = 0; k < NOUT; k++) outDiv_reg[k] <= ref_sel_pkg::OUT_DIV_RST;
      change_reg   <= 1'b0;
      readdata_reg <= 32'h00000000;
      waitreq_reg  <= 1'b1;
    end else begin
      ctrl_reg     <= ctrl_next;
      prio_reg     <= prio_next;
      bktId_reg    <= bktId_next;
      fastLoss_reg <= fastLoss_next;
      calWord_reg  <= calWord_next;
      syncCfg_reg  <= syncCfg_next;
      bktCfg_reg   <= bktCfg_next;
      outDiv_reg   <= outDiv_next;
      change_reg   <= change_next;
      readdata_reg <= readdata_next;
      waitreq_reg  <= waitreq_next;
    end
  end

  assign readdata            = readdata_reg;
  assign waitrequest         = waitreq_reg;
  assign freqWord            = freq_reg;
  assign operatingMode       = mode_reg;
  assign selectedRef         = sel_reg;
  assign frameSyncOut        = fSync_reg;
  assign multiframeSyncOut   = mfSync_reg;
  assign diffClockOut        = oClk[0];
  assign singleEndedClockOut = oClk[NOUT-1:1];

  // Checks
  logic autoRev;
  assign autoRev = !pinSync_reg && !ctrl_reg[ref_sel_pkg::CTRL_FORCE_EN] && ctrl_reg[ref_sel_pkg::CTRL_REVERTIVE];

  sequence holdEntry_s;
    mode_reg == ref_sel_pkg::LOCKED ##0 sel_next == ref_sel_pkg::REF_NONE;
  endsequence
  sequence frameStart_s;
    frm_next == 17'h00000 && !alignEdge ##1 frm_reg == 17'h00000;
  endsequence

  AST_ONE_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    mode_reg inside {ref_sel_pkg::FREE_RUN, ref_sel_pkg::LOCKED, ref_sel_pkg::HOLDOVER})
    else $error("mode outside the three operating modes");
  AST_RESET_FREE_RUN: assert property (@(posedge clk) !rst_n |=> mode_reg == ref_sel_pkg::FREE_RUN)
    else $error("not in free-run after reset");
  AST_LOCKED_HAS_REF: assert property (@(posedge clk) disable iff (!rst_n)
    mode_reg == ref_sel_pkg::LOCKED |-> $past(acq_reg) != 20'h0 || $past(mode_reg) == ref_sel_pkg::LOCKED)
    else $error("locked without acquisition");
  AST_HOLDOVER_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
    holdEntry_s |=> mode_reg == ref_sel_pkg::HOLDOVER)
    else $error("holdover not entered");
  AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
    holdEntry_s ##1 mode_reg == ref_sel_pkg::HOLDOVER [*2] |-> freq_reg == $past(freq_reg, 2))
    else $error("frequency word moved in holdover");
  AST_PRIORITY: assert property (@(posedge clk) disable iff (!rst_n)
    autoRev |=> sel_reg == $past(best))
    else $error("selection not best priority");
  AST_FORCE: assert property (@(posedge clk) disable iff (!rst_n)
    !pinSync_reg && ctrl_reg[ref_sel_pkg::CTRL_FORCE_EN] && isValid(refValid, ctrl_reg[3:2])
    |=> sel_reg == $past(ctrl_reg[3:2]))
    else $error("forced selection ignored");
  AST_PIN: assert property (@(posedge clk) disable iff (!rst_n)
    pinSync_reg && refValid[ref_sel_pkg::REF_SLAVE] |=> sel_reg == ref_sel_pkg::REF_SLAVE)
    else $error("forced-switch pin ignored");
  AST_NON_REVERTIVE: assert property (@(posedge clk) disable iff (!rst_n)
    !pinSync_reg && ctrl_reg[1:0] == 2'h0 && isValid(refValid, sel_reg) |=> $stable(sel_reg))
    else $error("non-revertive selection moved");
  AST_FRAME_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
    frameStart_s ##0 $stable(syncCfg_reg) |-> fSync_reg == ((syncCfg_reg[7:0] != 8'h00) ^ syncCfg_reg[16]))
    else $error("frame sync level wrong at frame start");

endmodule : reference_select_mode_control

// *** testbench/ref_card_model.sv ***
// Model of the three reference clock cards driving clock and sync pins
`timescale 1ns/1ps
module ref_card_model (
  // Clock and control
  input  wire logic       clk,
  input  wire logic [2:0] cardOn,
  // Pins
  output logic      [2:0] refClock = 3'h0,
  output logic      [2:0] syncRef = 3'h0
);
  logic [5:0] cnt_reg = 6'h00;
  always @(posedge clk) begin
    cnt_reg <= (cnt_reg == 6'h31) ? 6'h00 : cnt_reg + 6'h01;
    // A dead card stops its clock low instead of leaving it running
    refClock <= cardOn & {3{cnt_reg[1]}};
    // Sync dies with its own clock as one group
    syncRef <= cardOn & {3{cnt_reg == 6'h00}};
  end
endmodule : ref_card_model

// *** testbench/tb_top.sv ***
// Self-checking bench for reference select and mode control
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [18:0] loopFreqWord = 19'h2aaaa;
  logic [18:0] freqWord;
  logic [1:0]  operatingMode;
  logic [1:0]  selectedRef;
  logic        forcedSwitchPin = 1'b0;
  logic [2:0]  cardOn = 3'h0;
  logic [2:0]  refClock;
  logic [2:0]  syncRef;
  logic [31:0] rdata;
  wire [7:0]   outs;
  int          len = 0;
  int          failCount = 0;
  int          samplesChecked = 0;
  reference_select_mode_control #(.LOCK_CYCLES_P(20), .FRAME_CYCLES_P(50), .SYNC_8K_MAX_P(75),
    .SYNC_4K_MAX_P(150), .SYNC_2K_MAX_P(300)) u_reference_select_mode_control (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .masterRefClock(refClock[0]), .slaveRefClock(refClock[1]),
    .standbyRefClock(refClock[2]), .masterSyncRef(syncRef[0]), .slaveSyncRef(syncRef[1]),
    .standbySyncRef(syncRef[2]), .forcedSwitchPin(forcedSwitchPin), .loopFreqWord(loopFreqWord),
    .freqWord(freqWord), .operatingMode(operatingMode), .selectedRef(selectedRef), .frameSyncOut(outs[0]),
    .multiframeSyncOut(outs[1]), .diffClockOut(outs[2]), .singleEndedClockOut(outs[7:3]));
  ref_card_model u_ref_card_model (.clk(clk), .cardOn(cardOn), .refClock(refClock), .syncRef(syncRef));
  initial forever #5 clk = ~clk;
  task tally_and_finish;
    $display("Checks %0d, mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task bail;
    failCount++;
    $display("Error at %0t: wait timed out", $time);
    tally_and_finish();
  endtask : bail
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Request held until the edge that samples waitrequest low
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rdata = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) bail();
  endtask : acc
  task wait_for(input logic [1:0] s, input logic [1:0] m, input int lim);
    int n;
    n = 0;
    while ((selectedRef !== s || operatingMode !== m) && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) bail();
  endtask : wait_for
  // Length of the next whole run of level v on outs[b]; a partial run on entry is skipped
  task run_len(input int b, input logic v, output int cnt);
    int n;
    n = 0;
    cnt = 0;
    while (outs[b] === v && n < 1000) begin
      @(posedge clk);
      n++;
    end
    while (outs[b] !== v && n < 1000) begin
      @(posedge clk);
      n++;
    end
    while (outs[b] === v && n < 1000) begin
      @(posedge clk);
      n++;
      cnt++;
    end
    if (n >= 1000) bail();
  endtask : run_len
  task t_reset;
    acc(1'b0, ref_sel_pkg::OFS_PRIORITY, 32'h0);
    check(rdata, 32'h432);
    check(operatingMode, ref_sel_pkg::FREE_RUN);
    check(selectedRef, ref_sel_pkg::REF_NONE);
    acc(1'b0, 8'h60, 32'h0);
    check(rdata, 32'h0);
    acc(1'b1, ref_sel_pkg::OFS_CAL_WORD, 32'h1234);
    repeat (3) @(posedge clk);
    check(freqWord, 19'h01234);
  endtask : t_reset
  task t_lock;
    acc(1'b1, ref_sel_pkg::OFS_CTRL, 32'h11);
    cardOn <= 3'b111;
    wait_for(ref_sel_pkg::REF_MASTER, ref_sel_pkg::LOCKED, 5000);
    check(selectedRef, ref_sel_pkg::REF_MASTER);
    repeat (2) @(posedge clk);
    check(freqWord, loopFreqWord);
  endtask : t_lock
  task t_sync;
    // Frame sync inverted, 3 cycles wide; multiframe 2 cycles wide
    acc(1'b1, ref_sel_pkg::OFS_SYNC_CFG, 32'h00010203);
    repeat (60) @(posedge clk);
    run_len(0, 1'b0, len);
    check(len, 32'h3);
    // Card sync at count 0, three cycles of pin latency, then the 3-cycle pulse
    check(u_ref_card_model.cnt_reg, 32'h7);
    run_len(0, 1'b1, len);
    check(len, 32'h2f);
    run_len(1, 1'b1, len);
    check(len, 32'h2);
    run_len(1, 1'b0, len);
    check(len, 32'hc6);
    acc(1'b1, ref_sel_pkg::OFS_OUT_DIV0 + 8'h04, 32'h3);
    run_len(2, 1'b1, len);
    check(len, 32'h4);
    run_len(3, 1'b1, len);
    check(len, 32'h3);
    acc(1'b0, ref_sel_pkg::OFS_STATUS, 32'h0);
    check(rdata[12:0], {ref_sel_pkg::RATE_8K, ref_sel_pkg::RATE_8K, ref_sel_pkg::RATE_8K, 3'h7,
      ref_sel_pkg::REF_MASTER, 2'h1});
  endtask : t_sync
  task t_fail;
    // Bound far below six windows: only the fast path can meet it
    cardOn <= 3'b110;
    wait_for(ref_sel_pkg::REF_SLAVE, ref_sel_pkg::LOCKED, 100);
    check(selectedRef, ref_sel_pkg::REF_SLAVE);
    cardOn <= 3'b111;
    wait_for(ref_sel_pkg::REF_MASTER, ref_sel_pkg::LOCKED, 5000);
    check(operatingMode, ref_sel_pkg::LOCKED);
    forcedSwitchPin <= 1'b1;
    wait_for(ref_sel_pkg::REF_SLAVE, ref_sel_pkg::LOCKED, 20);
    check(selectedRef, ref_sel_pkg::REF_SLAVE);
    forcedSwitchPin <= 1'b0;
    acc(1'b1, ref_sel_pkg::OFS_PRIORITY, 32'h123);
    wait_for(ref_sel_pkg::REF_STANDBY, ref_sel_pkg::LOCKED, 50);
    check(selectedRef, ref_sel_pkg::REF_STANDBY);
    acc(1'b1, ref_sel_pkg::OFS_CTRL, 32'h16);
    wait_for(ref_sel_pkg::REF_SLAVE, ref_sel_pkg::LOCKED, 20);
    check(selectedRef, ref_sel_pkg::REF_SLAVE);
    acc(1'b1, ref_sel_pkg::OFS_CTRL, 32'h10);
    repeat (20) @(posedge clk);
    check(selectedRef, ref_sel_pkg::REF_SLAVE);
  endtask : t_fail
  task t_hold;
    cardOn <= 3'b000;
    wait_for(ref_sel_pkg::REF_NONE, ref_sel_pkg::HOLDOVER, 100);
    check(operatingMode, ref_sel_pkg::HOLDOVER);
    loopFreqWord <= 19'h15555;
    repeat (4) @(posedge clk);
    check(freqWord, 19'h2aaaa);
    acc(1'b0, ref_sel_pkg::OFS_STATUS, 32'h0);
    check(rdata[6:0], 7'h0e);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b0, ref_sel_pkg::OFS_PRIORITY, 32'h0);
    check(rdata, 32'h432);
    check(operatingMode, ref_sel_pkg::FREE_RUN);
    check(freqWord, ref_sel_pkg::CAL_WORD_RST);
  endtask : t_hold
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_lock();
    t_sync();
    t_fail();
    t_hold();
    tally_and_finish();
  end
endmodule : tb_top
